// ### verilog/rcc_regs.vh
// Register map, field layout and timing constants of the ROM command block
`ifndef RCC_REGS_VH
`define RCC_REGS_VH

// Register byte offsets
`define RCC_CMD_OFFSET      8'h40
`define RCC_DATA_OFFSET     8'h44

// Command/control register fields
`define RCC_BUSY_BIT        31
`define RCC_CODE_HI         30
`define RCC_CODE_LO         28
`define RCC_TIMEOUT_BIT     10
`define RCC_LOADED_BIT      9
`define RCC_PTR_HI          8
`define RCC_PTR_LO          0
`define RCC_DATA_HI         7

// Reset values
`define RCC_CODE_RESET      3'h0
`define RCC_PTR_RESET       9'h000
`define RCC_DATA_RESET      8'h00

// Command codes
`define RCC_CMD_READ        3'h0
`define RCC_CMD_LOCK        3'h1
`define RCC_CMD_UNLOCK      3'h2
`define RCC_CMD_WRITE       3'h3
`define RCC_CMD_FILL_ALL    3'h4
`define RCC_CMD_ERASE       3'h5
`define RCC_CMD_WIPE_ALL    3'h6
`define RCC_CMD_RELOAD      3'h7

// Serial opcodes and extended sub-opcodes
`define RCC_OP_EXT          2'h0
`define RCC_OP_WRITE        2'h1
`define RCC_OP_READ         2'h2
`define RCC_OP_ERASE        2'h3
`define RCC_SUB_LOCK        2'h0
`define RCC_SUB_FILL        2'h1
`define RCC_SUB_WIPE        2'h2
`define RCC_SUB_UNLOCK      2'h3
`define RCC_FRAME_LONG      5'h14
`define RCC_FRAME_SHORT     5'h0c

// Reload signature expected at ROM byte 0
`define RCC_SIGNATURE       8'ha5

// Timing
`define RCC_CLK_KHZ         250000
`define RCC_TIMEOUT_MS      30
`define RCC_SK_HALF         6
`define RCC_CS_GAP          4'h4
`define RCC_SETTLE          4'h4

`endif

// ### verilog/rcc_sync.v
// Two-stage synchroniser for levels entering the core clock domain
`timescale 1ns/1ps
module rcc_sync (
    input  wire i_core_clk,
    input  wire i_reset_n,
    input  wire i_async,
    output reg  o_sync
);
    reg stage1;

    always @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule // rcc_sync

// ### verilog/rcc_shift.v
// Three-wire serial shifter: drives select, clock and data out, samples data in
`timescale 1ns/1ps
module rcc_shift #(
    parameter HALF = 6,
    parameter NB   = 20
) (
    input  wire          i_core_clk,
    input  wire          i_reset_n,
    input  wire          i_start,
    input  wire [4:0]    i_nbits,
    input  wire [NB-1:0] i_frame,
    input  wire          i_poll,
    input  wire          i_rx_bit,
    output reg           o_cs,
    output reg           o_sk,
    output reg           o_do,
    output reg           o_done,
    output reg  [7:0]    o_rx
);
    localparam integer DIV_M1   = HALF - 1;
    localparam [7:0]   DIV_LAST = DIV_M1[7:0];

    reg          busy;
    reg [NB-1:0] shreg;
    reg [4:0]    cnt;
    reg [7:0]    div;

    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            busy   <= 1'b0;
            shreg  <= {NB{1'b0}};
            cnt    <= 5'h00;
            div    <= 8'h00;
            o_cs   <= 1'b0;
            o_sk   <= 1'b0;
            o_do   <= 1'b0;
            o_done <= 1'b0;
            o_rx   <= 8'h00;
        end else begin
            o_done <= 1'b0;
            if (!busy) begin
                // Select held high while idle only for ready polling
                o_cs <= i_poll;
                o_sk <= 1'b0;
                o_do <= 1'b0;
                div  <= 8'h00;
                if (i_start) begin
                    busy  <= 1'b1;
                    o_cs  <= 1'b1;
                    o_do  <= i_frame[NB-1];
                    shreg <= {i_frame[NB-2:0], 1'b0};
                    cnt   <= i_nbits;
                end
            end else if (div != DIV_LAST) begin
                div <= div + 8'h01;
            end else begin
                div <= 8'h00;
                if (!o_sk) begin
                    o_sk <= 1'b1;
                end else begin
                    o_sk <= 1'b0;
                    // Sampled on the falling edge: the part drives on rise
                    o_rx <= {o_rx[6:0], i_rx_bit};
                    if (cnt == 5'h01) begin
                        busy   <= 1'b0;
                        o_cs   <= 1'b0;
                        o_do   <= 1'b0;
                        o_done <= 1'b1;
                    end else begin
                        cnt   <= cnt - 5'h01;
                        o_do  <= shreg[NB-1];
                        shreg <= {shreg[NB-2:0], 1'b0};
                    end
                end
            end
        end
    end
endmodule // rcc_shift

// ### verilog/rcc_ctrl.v
// Serial ROM command controller: register slave and command sequencer
`timescale 1ns/1ps
`include "rcc_regs.vh"
module rcc_ctrl #(
    parameter integer TIMEOUT_CYCLES = `RCC_TIMEOUT_MS * `RCC_CLK_KHZ,
    parameter integer SK_HALF        = `RCC_SK_HALF
) (
    input  wire        i_core_clk,
    input  wire        i_reset_n,
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wr_data,
    input  wire        i_wr_en,
    input  wire        i_rd_en,
    output reg  [31:0] o_rd_data,
    output wire        o_rom_cs,
    output wire        o_rom_sk,
    output wire        o_rom_do,
    input  wire        i_rom_serial_in,
    output reg         o_op_in_progress,
    output reg         o_contents_loaded
);
    localparam NB = 20;
    localparam integer TMO_M1   = TIMEOUT_CYCLES - 1;
    localparam [22:0]  TMO_LAST = TMO_M1[22:0];

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_SEND = 3'h1;
    localparam [2:0] ST_GAP  = 3'h2;
    localparam [2:0] ST_POLL = 3'h3;
    localparam [2:0] ST_TAIL = 3'h4;

    // Programming commands are the only ones that wait for ready
    function is_prog;
        input [2:0] code;
        begin
            is_prog = (code == `RCC_CMD_WRITE) ||
                      (code == `RCC_CMD_FILL_ALL) ||
                      (code == `RCC_CMD_ERASE) ||
                      (code == `RCC_CMD_WIPE_ALL);
        end
    endfunction

    // Left-aligned frame: start bit, opcode, address, data
    function [NB-1:0] frame_of;
        input [2:0] code;
        input [8:0] ptr;
        input [7:0] data;
        begin
            case (code)
                `RCC_CMD_READ:     frame_of = {1'b1, `RCC_OP_READ, ptr, 8'h00};
                `RCC_CMD_LOCK:     frame_of = {1'b1, `RCC_OP_EXT,
                                               `RCC_SUB_LOCK, 15'h0000};
                `RCC_CMD_UNLOCK:   frame_of = {1'b1, `RCC_OP_EXT,
                                               `RCC_SUB_UNLOCK, 15'h0000};
                `RCC_CMD_WRITE:    frame_of = {1'b1, `RCC_OP_WRITE, ptr, data};
                `RCC_CMD_FILL_ALL: frame_of = {1'b1, `RCC_OP_EXT,
                                               `RCC_SUB_FILL, 7'h00, data};
                `RCC_CMD_ERASE:    frame_of = {1'b1, `RCC_OP_ERASE, ptr,
                                               8'h00};
                `RCC_CMD_WIPE_ALL: frame_of = {1'b1, `RCC_OP_EXT,
                                               `RCC_SUB_WIPE, 15'h0000};
                default:           frame_of = {1'b1, `RCC_OP_READ, 17'h00000};
            endcase
        end
    endfunction

    function [4:0] len_of;
        input [2:0] code;
        begin
            case (code)
                `RCC_CMD_READ,
                `RCC_CMD_WRITE,
                `RCC_CMD_FILL_ALL,
                `RCC_CMD_RELOAD:   len_of = `RCC_FRAME_LONG;
                default:           len_of = `RCC_FRAME_SHORT;
            endcase
        end
    endfunction

    reg  [2:0]    command_code;
    reg  [8:0]    rom_byte_pointer;
    reg  [7:0]    rom_data_byte;
    reg           op_in_progress;
    reg           no_response_timeout;
    reg           contents_loaded;
    reg           boot_pending;
    reg  [2:0]    run_code;
    reg  [2:0]    state;
    reg  [3:0]    gap_cnt;
    reg  [22:0]   tmr;
    reg           eng_start;
    reg  [NB-1:0] eng_frame;
    reg  [4:0]    eng_nbits;
    reg           poll;
    wire          eng_done;
    wire [7:0]    eng_rx;
    wire          serial_in_sync;

    wire cmd_wr  = i_wr_en && (i_addr == `RCC_CMD_OFFSET);
    wire data_wr = i_wr_en && (i_addr == `RCC_DATA_OFFSET);
    wire host_go = cmd_wr && i_wr_data[`RCC_BUSY_BIT] && !op_in_progress;
    wire [2:0] wr_code = i_wr_data[`RCC_CODE_HI:`RCC_CODE_LO];
    wire [8:0] wr_ptr  = i_wr_data[`RCC_PTR_HI:`RCC_PTR_LO];
    wire       loaded_clr = cmd_wr && i_wr_data[`RCC_LOADED_BIT];
    wire       tmo_clr    = cmd_wr && i_wr_data[`RCC_TIMEOUT_BIT];

    ////////////////////////////////////////////////////////////////////////
    rcc_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_async    (i_rom_serial_in),
        .o_sync     (serial_in_sync)
    );

    rcc_shift #(
        .HALF (SK_HALF),
        .NB   (NB)
    ) u_shift (
        .i_core_clk (i_core_clk),
        .i_reset_n  (i_reset_n),
        .i_start    (eng_start),
        .i_nbits    (eng_nbits),
        .i_frame    (eng_frame),
        .i_poll     (poll),
        .i_rx_bit   (serial_in_sync),
        .o_cs       (o_rom_cs),
        .o_sk       (o_rom_sk),
        .o_do       (o_rom_do),
        .o_done     (eng_done),
        .o_rx       (eng_rx)
    );

    ////////////////////////////////////////////////////////////////////////
    // Host-visible registers; code, pointer and data writes are dropped while busy so a
    // running frame never sees its operands change
    always @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            command_code     <= `RCC_CODE_RESET;
            rom_byte_pointer <= `RCC_PTR_RESET;
        end else if (cmd_wr && !op_in_progress) begin
            command_code     <= wr_code;
            rom_byte_pointer <= wr_ptr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer
    always @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state               <= ST_IDLE;
            op_in_progress      <= 1'b0;
            no_response_timeout <= 1'b0;
            contents_loaded     <= 1'b0;
            boot_pending        <= 1'b1;
            run_code            <= `RCC_CMD_READ;
            rom_data_byte       <= `RCC_DATA_RESET;
            gap_cnt             <= 4'h0;
            tmr                 <= 23'h000000;
            eng_start           <= 1'b0;
            eng_frame           <= {NB{1'b0}};
            eng_nbits           <= 5'h00;
            poll                <= 1'b0;
        end else begin
            eng_start <= 1'b0;
            if (data_wr && !op_in_progress) begin
                rom_data_byte <= i_wr_data[`RCC_DATA_HI:0];
            end
            if (tmo_clr) begin
                no_response_timeout <= 1'b0;
            end
            if (loaded_clr) begin
                contents_loaded <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (boot_pending) begin
                        // Power-up load runs as a reload from byte zero
                        boot_pending   <= 1'b0;
                        op_in_progress <= 1'b1;
                        run_code       <= `RCC_CMD_RELOAD;
                        eng_frame      <= frame_of(`RCC_CMD_RELOAD,
                                                   9'h000, 8'h00);
                        eng_nbits      <= len_of(`RCC_CMD_RELOAD);
                        eng_start      <= 1'b1;
                        state          <= ST_SEND;
                    end else if (host_go) begin
                        op_in_progress      <= 1'b1;
                        no_response_timeout <= 1'b0;
                        run_code            <= wr_code;
                        eng_frame <= frame_of(wr_code, wr_ptr,
                                              rom_data_byte);
                        eng_nbits <= len_of(wr_code);
                        eng_start <= 1'b1;
                        state     <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (eng_done) begin
                        if (is_prog(run_code)) begin
                            // Lock state lives in the part; it simply
                            // ignores these frames while locked
                            gap_cnt <= 4'h0;
                            state   <= ST_GAP;
                        end else begin
                            if (run_code == `RCC_CMD_READ) begin
                                rom_data_byte <= eng_rx;
                            end
                            if (run_code == `RCC_CMD_RELOAD &&
                                eng_rx == `RCC_SIGNATURE) begin
                                contents_loaded <= 1'b1;
                            end
                            // Failed reload touches nothing else
                            gap_cnt <= 4'h0;
                            state   <= ST_TAIL;
                        end
                    end
                end
                ST_GAP: begin
                    // Select must stay low a while before ready polling
                    if (gap_cnt == `RCC_CS_GAP) begin
                        gap_cnt <= 4'h0;
                        tmr     <= 23'h000000;
                        poll    <= 1'b1;
                        state   <= ST_POLL;
                    end else begin
                        gap_cnt <= gap_cnt + 4'h1;
                    end
                end
                ST_POLL: begin
                    if (gap_cnt != `RCC_SETTLE) begin
                        // Let select reach the part and its answer cross
                        // the synchroniser before trusting the level
                        gap_cnt <= gap_cnt + 4'h1;
                    end else if (serial_in_sync) begin
                        poll    <= 1'b0;
                        gap_cnt <= 4'h0;
                        state   <= ST_TAIL;
                    end
                    if (tmr == TMO_LAST) begin
                        poll                <= 1'b0;
                        no_response_timeout <= 1'b1;
                        gap_cnt             <= 4'h0;
                        state               <= ST_TAIL;
                    end else begin
                        tmr <= tmr + 23'h000001;
                    end
                end
                ST_TAIL: begin
                    // Busy outlasts the frame so that even a host writing
                    // at once cannot cut the select rest short
                    if (gap_cnt == `RCC_CS_GAP) begin
                        gap_cnt        <= 4'h0;
                        op_in_progress <= 1'b0;
                        state          <= ST_IDLE;
                    end else begin
                        gap_cnt <= gap_cnt + 4'h1;
                    end
                end
                default: begin
                    poll  <= 1'b0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data valid only in the cycle after the strobe
    always @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_rd_data         <= 32'h00000000;
            o_op_in_progress  <= 1'b0;
            o_contents_loaded <= 1'b0;
        end else begin
            o_op_in_progress  <= op_in_progress;
            o_contents_loaded <= contents_loaded;
            o_rd_data         <= 32'h00000000;
            if (i_rd_en && i_addr == `RCC_CMD_OFFSET) begin
                o_rd_data[`RCC_BUSY_BIT]            <= op_in_progress;
                o_rd_data[`RCC_CODE_HI:`RCC_CODE_LO] <= command_code;
                o_rd_data[`RCC_TIMEOUT_BIT]         <= no_response_timeout;
                o_rd_data[`RCC_LOADED_BIT]          <= contents_loaded;
                o_rd_data[`RCC_PTR_HI:`RCC_PTR_LO]  <= rom_byte_pointer;
            end else if (i_rd_en && i_addr == `RCC_DATA_OFFSET) begin
                o_rd_data[`RCC_DATA_HI:0] <= rom_data_byte;
            end
        end
    end
endmodule // rcc_ctrl

// ### verif/rcc_ctrl_checker.sv
// Port-level checks on the ROM command controller
`timescale 1ns/1ps
module rcc_ctrl_checker #(
    parameter integer TIMEOUT_CYCLES = 200
) (
    input wire        i_core_clk,
    input wire        i_reset_n,
    input wire [7:0]  i_addr,
    input wire [31:0] i_wr_data,
    input wire        i_wr_en,
    input wire        i_rd_en,
    input wire [31:0] o_rd_data,
    input wire        o_rom_cs,
    input wire        o_rom_sk,
    input wire        o_rom_do,
    input wire        i_rom_serial_in,
    input wire        o_op_in_progress,
    input wire        o_contents_loaded
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);
    ////////////////////////////////////////////////////////////////////////
    integer busy_len;
    wire    cmd_wr = i_wr_en && i_addr == 8'h40 && !o_op_in_progress;
    always @(posedge i_core_clk) begin
        if (!i_reset_n || !o_op_in_progress)
            busy_len <= 0;
        else
            busy_len <= busy_len + 1;
    end
    sequence s_frame_open;
        o_op_in_progress && o_rom_cs && o_rom_do;
    endsequence
    sequence s_first_rise;
        !o_rom_sk [*6] ##1 o_rom_sk;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_cmd_opens_frame: assert property (cmd_wr && i_wr_data[31] |->
        ##2 s_frame_open ##0 s_first_rise) else $error("frame start");
    // Worst case is a full frame plus the whole polling limit
    a_busy_bounded: assert property (busy_len < TIMEOUT_CYCLES + 400)
        else $error("busy too long");
    a_rd_idle_zero: assert property (!$past(i_rd_en) |-> o_rd_data == 0)
        else $error("read data not idle");
    a_unmapped_zero: assert property ($past(i_rd_en) &&
        $past(i_addr) != 8'h40 && $past(i_addr) != 8'h44 |-> o_rd_data == 0)
        else $error("unmapped read");
    a_data_upper_zero: assert property ($past(i_rd_en) &&
        $past(i_addr) == 8'h44 |-> o_rd_data[31:8] == 0)
        else $error("data upper bits");
    a_cmd_reserved_zero: assert property ($past(i_rd_en) &&
        $past(i_addr) == 8'h40 |-> o_rd_data[27:11] == 0)
        else $error("reserved bits");
    a_sk_in_frame: assert property (o_rom_sk |-> o_rom_cs)
        else $error("clock outside frame");
    a_sk_half_period: assert property ($rose(o_rom_sk) |->
        o_rom_sk [*6] ##1 !o_rom_sk) else $error("clock high time");
    a_do_steady_high: assert property (o_rom_sk && $past(o_rom_sk) |->
        $stable(o_rom_do)) else $error("data moved in high phase");
    a_cs_gap: assert property ($fell(o_rom_cs) |-> !o_rom_cs [*5])
        else $error("select gap");
    a_idle_cs_low: assert property (!o_op_in_progress [*3] |-> !o_rom_cs)
        else $error("select while idle");
    a_loaded_clear: assert property (cmd_wr && !i_wr_data[31] &&
        i_wr_data[9] |-> ##2 !o_contents_loaded) else $error("loaded clear");
endmodule // rcc_ctrl_checker

bind rcc_ctrl rcc_ctrl_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
    rcc_ctrl_checker_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_rom_cs(o_rom_cs),
    .o_rom_sk(o_rom_sk), .o_rom_do(o_rom_do),
    .i_rom_serial_in(i_rom_serial_in), .o_op_in_progress(o_op_in_progress),
    .o_contents_loaded(o_contents_loaded));

// ### verif/rcc_rom_model.sv
// Behavioural serial ROM on the far side of the three-wire link
`timescale 1ns/1ps
module rcc_rom_model (
    input  wire i_cs,
    input  wire i_sk,
    input  wire i_di,
    output wire o_do
);
    reg [7:0]  mem [0:511];
    reg [19:0] sr;
    reg [19:0] f;
    reg [8:0]  ra;
    reg        rdop, unlocked, busy, polling, in_poll, drv, present, lvl;
    integer    cnt, prog_ns, i;
    initial begin
        for (i = 0; i < 512; i = i + 1)
            mem[i] = i[7:0] + 8'h11;
        mem[0] = 8'ha5;
        unlocked = 1'b0;
        {busy, polling, in_poll, rdop} = 4'h0;
        {drv, present, lvl} = 3'h7;
        cnt = 0;
        prog_ns = 0;
    end
    // Released line is pulled up; a missing part leaves only the bench level
    assign o_do = !present ? lvl : !i_cs ? 1'b1 : polling ? !busy : drv;
    always @(posedge i_cs) begin
        cnt = 0;
        drv = 1'b1;
        rdop = 1'b0;
        in_poll = polling;
    end
    always @(posedge i_sk) begin
        if (i_cs && !in_poll) begin
            sr = {sr[18:0], i_di};
            cnt = cnt + 1;
            if (cnt == 12) begin
                rdop = sr[11:9] == 3'h6;
                ra = sr[8:0];
            end
            if (rdop && cnt >= 12 && cnt <= 20)
                drv = (cnt == 12) ? 1'b0 : mem[ra][20 - cnt];
        end
    end
    // Programming is applied when select drops, as a real part does
    always @(negedge i_cs) begin
        if (in_poll)
            polling = 1'b0;
        else if (cnt == 12 || cnt == 20) begin
            f = (cnt == 20) ? sr : {sr[11:0], 8'h00};
            polling = f[18:17] != 2'h2;
            case (f[18:17])
                2'h1: if (unlocked) mem[f[16:8]] = f[7:0];
                2'h3: if (unlocked) mem[f[16:8]] = 8'hff;
                2'h0: begin
                    if (f[16:15] == 2'h0 || f[16:15] == 2'h3)
                        polling = 1'b0;
                    if (f[16:15] == 2'h0)
                        unlocked = 1'b0;
                    else if (f[16:15] == 2'h3)
                        unlocked = 1'b1;
                    else if (unlocked)
                        for (i = 0; i < 512; i = i + 1)
                            mem[i] = f[15] ? f[7:0] : 8'hff;
                end
                default: ;
            endcase
            busy = polling && unlocked && prog_ns > 0;
            if (busy)
                #(prog_ns) busy = 1'b0;
        end
    end
endmodule // rcc_rom_model

// ### verif/rcc_ctrl_test.sv
// Self-checking bench for the ROM command controller
`timescale 1ns/1ps
module rcc_ctrl_test;
    localparam  TMO  = 200;
    localparam  BASE = 20 * 12 + 9;
    reg         i_core_clk, i_reset_n, i_wr_en, i_rd_en;
    reg  [7:0]  i_addr;
    reg  [31:0] i_wr_data;
    wire [31:0] o_rd_data;
    wire        o_rom_cs, o_rom_sk, o_rom_do, rom_q;
    wire        o_op_in_progress, o_contents_loaded;
    integer     n_mismatch, n_compared, cyc, len;
    rcc_ctrl #(.TIMEOUT_CYCLES(TMO), .SK_HALF(6)) rcc_ctrl_inst (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
        .o_rd_data(o_rd_data), .o_rom_cs(o_rom_cs), .o_rom_sk(o_rom_sk),
        .o_rom_do(o_rom_do), .i_rom_serial_in(rom_q),
        .o_op_in_progress(o_op_in_progress),
        .o_contents_loaded(o_contents_loaded));
    rcc_rom_model rom (.i_cs(o_rom_cs), .i_sk(o_rom_sk), .i_di(o_rom_do),
        .o_do(rom_q));
    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        begin
            if (n_mismatch == 0 && n_compared > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input [8*10-1:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge i_core_clk);
            i_wr_en <= 1'b1;
            i_addr <= a;
            i_wr_data <= d;
            @(posedge i_core_clk);
            i_wr_en <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            @(posedge i_core_clk);
            i_rd_en <= 1'b1;
            i_addr <= a;
            @(posedge i_core_clk);
            i_rd_en <= 1'b0;
            #1 chk("read data", e, o_rd_data);
        end
    endtask
    // Busy output lags the start by two cycles, so look only after that
    task idle;
        begin
            len = 0;
            repeat (4) @(posedge i_core_clk);
            #1;
            while (o_op_in_progress !== 1'b0 && len < 3000) begin
                @(posedge i_core_clk);
                #1 len = len + 1;
            end
            if (len >= 3000)
                chk("idle wait", 0, 1);
        end
    endtask
    task cmd(input [2:0] c, input [8:0] p);
        begin
            wr(8'h40, {1'b1, c, 19'h0, p});
            idle;
        end
    endtask
    function [31:0] ec(input [2:0] c, input t, input l, input [8:0] p);
        ec = {1'b0, c, 17'h0, t, l, p};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end
    initial begin
        {n_mismatch, n_compared, cyc} = 0;
        {i_reset_n, i_wr_en, i_rd_en, i_addr, i_wr_data} = 0;
        repeat (6) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        idle;
        rd(8'h40, ec(0, 0, 1, 0));
        chk("loaded", 1, o_contents_loaded);
        rd(8'h48, 0);
        wr(8'h40, 32'h200);
        rd(8'h40, ec(0, 0, 0, 0));
        wr(8'h44, 32'h3c);
        cmd(3'h3, 9'h1ff);
        cmd(3'h0, 9'h1ff);
        rd(8'h44, 32'h10);
        cmd(3'h2, 9'h0);
        rom.prog_ns = 400;
        wr(8'h44, 32'h3c);
        wr(8'h40, 32'hb00001ff);
        rd(8'h40, 32'hb00001ff);
        idle;
        rom.prog_ns = 0;
        cmd(3'h0, 9'h1ff);
        rd(8'h44, 32'h3c);
        cmd(3'h5, 9'h1ff);
        cmd(3'h0, 9'h1ff);
        rd(8'h44, 32'hff);
        wr(8'h44, 32'h5a);
        cmd(3'h4, 9'h0);
        cmd(3'h0, 9'h100);
        rd(8'h44, 32'h5a);
        wr(8'h44, 32'h33);
        cmd(3'h7, 9'h0);
        rd(8'h40, ec(7, 0, 0, 0));
        rd(8'h44, 32'h33);
        cmd(3'h6, 9'h0);
        cmd(3'h0, 9'h0);
        rd(8'h44, 32'hff);
        wr(8'h44, 32'ha5);
        cmd(3'h3, 9'h0);
        cmd(3'h7, 9'h0);
        rd(8'h40, ec(7, 0, 1, 0));
        cmd(3'h1, 9'h5);
        wr(8'h44, 32'h77);
        cmd(3'h3, 9'h5);
        cmd(3'h0, 9'h5);
        rd(8'h44, 32'hff);
        rom.present = 1'b0;
        cmd(3'h3, 9'h5);
        chk("no wait", 1, len < BASE + TMO / 2);
        rd(8'h40, ec(3, 0, 1, 5));
        rom.lvl = 1'b0;
        cmd(3'h0, 9'h5);
        rd(8'h40, ec(0, 0, 1, 5));
        cmd(3'h3, 9'h5);
        chk("long wait", 1, len >= BASE + TMO - 10);
        rd(8'h40, ec(3, 1, 1, 5));
        cmd(3'h1, 9'h5);
        rd(8'h40, ec(1, 0, 1, 5));
        stop_test;
    end
endmodule // rcc_ctrl_test
